/* File: rtl/wke_consts.vh */
// Offsets, bit positions, reset values and timing counts of the wake-event block
`ifndef WKE_CONSTS_VH
`define WKE_CONSTS_VH

`define WKE_OFF_GLOBAL      8'h00
`define WKE_OFF_STS1        8'h01
`define WKE_OFF_STS2        8'h02
`define WKE_OFF_STS3        8'h03
`define WKE_OFF_EN1         8'h04
`define WKE_OFF_EN2         8'h05
`define WKE_OFF_EN3         8'h06
`define WKE_OFF_GPIO_42_CTRL        8'h07
`define WKE_OFF_SMI_ENABLE_2     8'h08
`define WKE_OFF_GPIO_POL    8'h09
`define WKE_OFF_GPIO_EITHER_EDGE_TRIGGER   8'h0A
`define WKE_OFF_KEY_CODE    8'h5F
`define WKE_OFF_CLK32       8'hF0

`define WKE_GLB_STS_BIT     0
`define WKE_GLB_EN_BIT      1
`define WKE_STS1_RI1_BIT    0
`define WKE_STS1_RI2_BIT    1
`define WKE_STS1_KDAT_BIT   2
`define WKE_STS1_MDAT_BIT   3
`define WKE_STS1_IR_BIT     4
`define WKE_STS1_KEY_BIT    5
`define WKE_STS1_FAN_BIT    6
`define WKE_STS3_SMI_BIT    3
`define WKE_SMI2_PME_BIT    5
`define WKE_GPIO_42_CTRL_POL_BIT    1
`define WKE_GPIO_42_CTRL_OD_BIT     7
`define WKE_CLK32_SRC_BIT   0
`define WKE_CLK32_OFF_BIT   1

`define WKE_RST_ZERO        8'h00
`define WKE_RST_GPIO_42_CTRL        8'h82
`define WKE_RST_CLK32       8'h00

`define WKE_CLK_HZ          64'd125000000
`define WKE_CLK32_HZ        64'd32768
`define WKE_NS_PER_S        64'd1000000000
`define WKE_KEY_IDLE_NS     64'd115000
`define WKE_KEY_GAP_NS      64'd145000
`define WKE_CLK32_DIV       (`WKE_CLK_HZ / `WKE_CLK32_HZ)
`define WKE_KEY_IDLE_TICKS  ((`WKE_KEY_IDLE_NS * `WKE_CLK32_HZ + `WKE_NS_PER_S - 64'd1) / `WKE_NS_PER_S)
`define WKE_KEY_GAP_TICKS   ((`WKE_KEY_GAP_NS * `WKE_CLK32_HZ) / `WKE_NS_PER_S)

`endif

/* File: rtl/wke_sync.v */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module wke_sync #(
    parameter W = 1
) (
    input  wire         i_clk,
    input  wire         i_nrst,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // wke_sync

/* File: rtl/wke_key_det.v */
// Keyboard frame decoder that flags a programmed scan code
`timescale 1ns/1ps
`include "wke_consts.vh"
module wke_key_det (
    input  wire       i_clk,
    input  wire       i_nrst,
    input  wire       i_on,
    input  wire       i_tick,
    input  wire       i_kclk,
    input  wire       i_kdata,
    input  wire [7:0] i_code,
    output wire       o_match
);
    localparam [63:0] IDLE_W = `WKE_KEY_IDLE_TICKS;
    localparam [63:0] GAP_W  = `WKE_KEY_GAP_TICKS;
    localparam [3:0]  IDLE_TICKS = IDLE_W[3:0];
    localparam [3:0]  GAP_TICKS  = GAP_W[3:0];

    reg       kclk_prev_q;
    reg [3:0] hi_cnt_q;
    reg       busy_q;
    reg [3:0] edge_q;
    reg [8:0] shift_q;
    reg       match_q;
    wire      fall;
    wire      frame_ok;

    assign fall = kclk_prev_q & ~i_kclk;
    // Data equals code and data plus parity hold an odd count of ones
    assign frame_ok = (shift_q[7:0] == i_code) && (^shift_q);

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            kclk_prev_q <= 1'b0;
            hi_cnt_q    <= 4'h0;
            busy_q      <= 1'b0;
            edge_q      <= 4'h0;
            shift_q     <= 9'h000;
            match_q     <= 1'b0;
        end
        else if (!i_on)
        begin
            // Held in reset while switched off
            kclk_prev_q <= 1'b0;
            hi_cnt_q    <= 4'h0;
            busy_q      <= 1'b0;
            edge_q      <= 4'h0;
            shift_q     <= 9'h000;
            match_q     <= 1'b0;
        end
        else
        begin
            kclk_prev_q <= i_kclk;
            match_q     <= 1'b0;
            if (!i_kclk)
                hi_cnt_q <= 4'h0;
            else if (i_tick && hi_cnt_q != 4'hF)
                hi_cnt_q <= hi_cnt_q + 4'h1;
            if (busy_q && hi_cnt_q > GAP_TICKS)
            begin
                busy_q <= 1'b0;
                edge_q <= 4'h0;
            end
            else if (fall)
            begin
                if (!busy_q)
                begin
                    // Start bit after a long enough idle-high stretch
                    if (hi_cnt_q >= IDLE_TICKS && !i_kdata)
                    begin
                        busy_q <= 1'b1;
                        edge_q <= 4'h1;
                    end
                end
                else if (edge_q < 4'hA)
                begin
                    shift_q <= {i_kdata, shift_q[8:1]};
                    edge_q  <= edge_q + 4'h1;
                end
                else
                begin
                    match_q <= frame_ok & i_kdata;
                    busy_q  <= 1'b0;
                    edge_q  <= 4'h0;
                end
            end
        end
    end

    assign o_match = match_q;
endmodule // wke_key_det

/* File: rtl/wke_top.v */
// Wake-event gathering, status and enable registers and wake pin driver
`timescale 1ns/1ps
`include "wke_consts.vh"
module wke_top #(
    parameter N_GPIO = 8
) (
    input  wire              i_clk,
    input  wire              i_nrst,
    input  wire              i_standby_nrst,
    input  wire [7:0]        i_reg_addr,
    input  wire [7:0]        i_reg_wdata,
    input  wire              i_reg_wr,
    input  wire              i_reg_rd,
    output reg  [7:0]        o_reg_rdata,
    input  wire              i_ring_indicator_1_n,
    input  wire              i_ring_indicator_2_n,
    input  wire              i_kbd_clk,
    input  wire              i_kbd_data,
    input  wire              i_mouse_data,
    input  wire [N_GPIO-1:0] i_gpio,
    input  wire              i_ext_clock32,
    input  wire              i_ir_frame_valid,
    input  wire              i_fan_event,
    input  wire              i_group_smi,
    output reg               o_wake_event_out,
    output reg               o_wake_event_oe
);
    // GPIO pins plus six fixed pins
    localparam SW = N_GPIO + 6;
    // Internal divider end count for a 32 kHz tick
    localparam [63:0] DIV_W = `WKE_CLK32_DIV;
    localparam [11:0] DIV_LAST = DIV_W[11:0] - 12'h001;

    // Synchronised pins and their previous values
    wire [SW-1:0] pin_s;
    reg  [SW-1:0] pin_prev_q;

    wke_sync #(
        .W (SW)
    ) u_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_async ({i_ext_clock32, i_mouse_data, i_kbd_data, i_kbd_clk,
                   i_ring_indicator_2_n, i_ring_indicator_1_n, i_gpio}),
        .o_sync  (pin_s)
    );

    wire [N_GPIO-1:0] gpio_s   = pin_s[N_GPIO-1:0];
    wire              ri1_s    = pin_s[N_GPIO];
    wire              ri2_s    = pin_s[N_GPIO+1];
    wire              kclk_s   = pin_s[N_GPIO+2];
    wire              kdat_s   = pin_s[N_GPIO+3];
    wire              mdat_s   = pin_s[N_GPIO+4];
    wire              ext32_s  = pin_s[N_GPIO+5];

    // Registers
    reg              glb_sts_q;
    reg              glb_en_q;
    reg  [7:0]       sts1_q;
    reg  [N_GPIO-1:0] sts2_q;
    reg              sts3_smi_q;

    // Enables and pin control
    reg  [7:0]       en1_q;
    reg  [N_GPIO-1:0] en2_q;
    reg  [7:0]       en3_q;
    reg  [7:0]       gpio_42_ctrl_q;
    reg  [7:0]       smi2_q;
    reg  [N_GPIO-1:0] gpio_pol_q;
    reg  [N_GPIO-1:0] gpio_either_edge_trigger_q;

    // Detector control
    reg  [7:0]       key_code_q;
    reg  [7:0]       clk32_q;

    // Divider, tick and post-reset edge mask
    reg  [11:0]      div_q;
    reg              tick_q;
    reg              ext32_prev_q;
    reg  [1:0]       arm_q;

    // Write strobes of the write-one-clear registers
    wire wr_glb  = i_reg_wr && i_reg_addr == `WKE_OFF_GLOBAL;
    wire wr_sts1 = i_reg_wr && i_reg_addr == `WKE_OFF_STS1;
    wire wr_sts2 = i_reg_wr && i_reg_addr == `WKE_OFF_STS2;
    wire wr_sts3 = i_reg_wr && i_reg_addr == `WKE_OFF_STS3;

    // Detector runs while the off bit is clear
    wire det_on = ~clk32_q[`WKE_CLK32_OFF_BIT];
    // GPIO pin edges count once the synchroniser holds real pin values
    wire armed  = (arm_q == 2'h3);

    // 32 kHz tick from external pin or from the divided system clock
    wire ext_tick = ext32_s & ~ext32_prev_q;
    wire int_tick = (div_q == DIV_LAST);
    wire sel_tick = clk32_q[`WKE_CLK32_SRC_BIT] ? ext_tick : int_tick;

    // Free-running divider; tick dropped while detector off
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_q        <= 12'h000;
            tick_q       <= 1'b0;
            ext32_prev_q <= 1'b0;
        end
        else
        begin
            div_q        <= int_tick ? 12'h000 : div_q + 12'h001;
            ext32_prev_q <= ext32_s;
            tick_q       <= sel_tick & det_on;
        end
    end

    // Masks GPIO edges for the first three clock cycles after reset
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            arm_q <= 2'h0;
        else if (!armed)
            arm_q <= arm_q + 2'h1;
    end

    // Key detector advanced by the selected tick
    wire key_match;

    wke_key_det u_key_det (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_on    (det_on),
        .i_tick  (tick_q),
        .i_kclk  (kclk_s),
        .i_kdata (kdat_s),
        .i_code  (key_code_q),
        .o_match (key_match)
    );

    // GPIO edge events, one per pin
    wire [N_GPIO-1:0] gpio_ev;
    genvar g;
    generate
        for (g = 0; g < N_GPIO; g = g + 1)
        begin : g_gpio
            wire rise = gpio_s[g] & ~pin_prev_q[g];
            wire fall = ~gpio_s[g] & pin_prev_q[g];
            assign gpio_ev[g] = armed & (gpio_either_edge_trigger_q[g] ? (rise | fall) :
                                         gpio_pol_q[g]  ? fall : rise);
        end
    endgenerate

    // Fixed-source events; ring indicators active on the falling edge
    wire [7:0] ev1;
    assign ev1[`WKE_STS1_RI1_BIT]  = pin_prev_q[N_GPIO] & ~ri1_s;
    assign ev1[`WKE_STS1_RI2_BIT]  = pin_prev_q[N_GPIO+1] & ~ri2_s;
    assign ev1[`WKE_STS1_KDAT_BIT] = pin_prev_q[N_GPIO+3] & ~kdat_s;
    assign ev1[`WKE_STS1_MDAT_BIT] = pin_prev_q[N_GPIO+4] & ~mdat_s;
    assign ev1[`WKE_STS1_IR_BIT]   = i_ir_frame_valid;
    assign ev1[`WKE_STS1_KEY_BIT]  = key_match;
    assign ev1[`WKE_STS1_FAN_BIT]  = i_fan_event;
    assign ev1[7]                  = 1'b0;

    // Group interrupt routed into status 3
    wire smi_ev = i_group_smi & smi2_q[`WKE_SMI2_PME_BIT];

    // Key match only counts while the detector runs
    wire [7:0] en1_eff = en1_q & ~({7'h00, ~det_on} << `WKE_STS1_KEY_BIT);
    // Any enabled status still set
    wire pending = (|(sts1_q & en1_eff)) | (|(sts2_q & en2_q)) |
                   (sts3_smi_q & en3_q[`WKE_STS3_SMI_BIT]);

    // Set wins over write-one clear for every status bit
    wire [7:0]        sts1_d = (sts1_q & ~(wr_sts1 ? i_reg_wdata : 8'h00)) | ev1;
    wire [N_GPIO-1:0] sts2_d = (sts2_q & ~(wr_sts2 ? i_reg_wdata[N_GPIO-1:0] : {N_GPIO{1'b0}})) | gpio_ev;
    wire              sts3_d = (sts3_smi_q & ~(wr_sts3 & i_reg_wdata[`WKE_STS3_SMI_BIT])) | smi_ev;
    wire              glb_d  = pending |
                               (glb_sts_q & ~(wr_glb & i_reg_wdata[`WKE_GLB_STS_BIT]));

    // Status, enable and control registers
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pin_prev_q  <= {SW{1'b0}};
            glb_sts_q   <= 1'b0;
            glb_en_q    <= 1'b0;
            sts1_q      <= `WKE_RST_ZERO;
            sts2_q      <= {N_GPIO{1'b0}};
            sts3_smi_q  <= 1'b0;
            en1_q       <= `WKE_RST_ZERO;
            en2_q       <= {N_GPIO{1'b0}};
            en3_q       <= `WKE_RST_ZERO;
            gpio_42_ctrl_q      <= `WKE_RST_GPIO_42_CTRL;
            smi2_q      <= `WKE_RST_ZERO;
            gpio_pol_q  <= {N_GPIO{1'b0}};
            gpio_either_edge_trigger_q <= {N_GPIO{1'b0}};
            clk32_q     <= `WKE_RST_CLK32;
        end
        else
        begin
            pin_prev_q <= pin_s;
            glb_sts_q  <= glb_d;
            sts1_q     <= sts1_d;
            sts2_q     <= sts2_d;
            sts3_smi_q <= sts3_d;
            // Global enable shares the global status offset
            if (wr_glb)
                glb_en_q <= i_reg_wdata[`WKE_GLB_EN_BIT];
            // Plain read-write registers
            if (i_reg_wr)
            begin
                case (i_reg_addr)
                    `WKE_OFF_EN1:       en1_q       <= i_reg_wdata;
                    `WKE_OFF_EN2:       en2_q       <= i_reg_wdata[N_GPIO-1:0];
                    `WKE_OFF_EN3:       en3_q       <= i_reg_wdata;
                    `WKE_OFF_GPIO_42_CTRL:      gpio_42_ctrl_q      <= i_reg_wdata;
                    `WKE_OFF_SMI_ENABLE_2:   smi2_q      <= i_reg_wdata;
                    `WKE_OFF_GPIO_POL:  gpio_pol_q  <= i_reg_wdata[N_GPIO-1:0];
                    `WKE_OFF_GPIO_EITHER_EDGE_TRIGGER: gpio_either_edge_trigger_q <= i_reg_wdata[N_GPIO-1:0];
                    `WKE_OFF_CLK32:     clk32_q     <= i_reg_wdata;
                    default:            clk32_q     <= clk32_q;
                endcase
            end
        end
    end

    // Scan code kept on standby power
    always @(posedge i_clk or negedge i_standby_nrst)
    begin
        if (!i_standby_nrst)
            key_code_q <= `WKE_RST_ZERO;
        else if (i_reg_wr && i_reg_addr == `WKE_OFF_KEY_CODE)
            key_code_q <= i_reg_wdata;
    end

    // Read path, one cycle after the read strobe
    reg [7:0] rd_d;
    always @*
    begin
        // Bits above the GPIO count read zero
        rd_d = 8'h00;
        case (i_reg_addr)
            `WKE_OFF_GLOBAL:    rd_d = {6'h00, glb_en_q, glb_sts_q};
            `WKE_OFF_STS1:      rd_d = sts1_q;
            `WKE_OFF_STS2:      rd_d[N_GPIO-1:0] = sts2_q;
            `WKE_OFF_STS3:      rd_d[`WKE_STS3_SMI_BIT] = sts3_smi_q;
            `WKE_OFF_EN1:       rd_d = en1_q;
            `WKE_OFF_EN2:       rd_d[N_GPIO-1:0] = en2_q;
            `WKE_OFF_EN3:       rd_d = en3_q;
            `WKE_OFF_GPIO_42_CTRL:      rd_d = gpio_42_ctrl_q;
            `WKE_OFF_SMI_ENABLE_2:   rd_d = smi2_q;
            `WKE_OFF_GPIO_POL:  rd_d[N_GPIO-1:0] = gpio_pol_q;
            `WKE_OFF_GPIO_EITHER_EDGE_TRIGGER: rd_d[N_GPIO-1:0] = gpio_either_edge_trigger_q;
            `WKE_OFF_KEY_CODE:  rd_d = key_code_q;
            `WKE_OFF_CLK32:     rd_d = clk32_q;
            default:            rd_d = 8'h00;
        endcase
    end

    // Wake pin: level from polarity bit, drive type from bit 7
    wire wake_active = glb_en_q & pending;
    wire wake_level  = wake_active ^ gpio_42_ctrl_q[`WKE_GPIO_42_CTRL_POL_BIT];
    wire od_mode     = gpio_42_ctrl_q[`WKE_GPIO_42_CTRL_OD_BIT];

    // Open-drain only ever drives low
    // Read data held until the next read
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_reg_rdata      <= 8'h00;
            o_wake_event_out <= 1'b0;
            o_wake_event_oe  <= 1'b0;
        end
        else
        begin
            if (i_reg_rd)
                o_reg_rdata <= rd_d;
            o_wake_event_out <= od_mode ? 1'b0 : wake_level;
            o_wake_event_oe  <= od_mode ? ~wake_level : 1'b1;
        end
    end
endmodule // wke_top

/* File: verif/wke_top_sva.sv */
// Wake pin and register readback assertions for wke_top
`timescale 1ns/1ps
module wke_top_sva (
    input wire       i_clk,
    input wire       i_nrst,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire       i_reg_wr,
    input wire       i_reg_rd,
    input wire [7:0] o_reg_rdata,
    input wire       i_fan_event,
    input wire       i_group_smi,
    input wire       o_wake_event_out,
    input wire       o_wake_event_oe
);
    reg  [7:0] glb_q;
    reg  [7:0] en1_q;
    reg  [7:0] en3_q;
    reg  [7:0] smi_q;
    reg  [7:0] gp_q;
    // Pin level with pull-up, turned to active sense
    wire       act = (o_wake_event_oe ? o_wake_event_out : 1'b1) ^ gp_q[1];

    // Shadow copies of the control registers
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            glb_q <= 8'h00;
            en1_q <= 8'h00;
            en3_q <= 8'h00;
            smi_q <= 8'h00;
            gp_q  <= 8'h82;
        end
        else if (i_reg_wr)
        begin
            case (i_reg_addr)
                8'h00: glb_q <= i_reg_wdata;
                8'h04: en1_q <= i_reg_wdata;
                8'h06: en3_q <= i_reg_wdata;
                8'h07: gp_q <= i_reg_wdata;
                8'h08: smi_q <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_fan_armed;
        (i_fan_event && en1_q[6] && glb_q[1] && !i_reg_wr) ##1 !i_reg_wr;
    endsequence
    sequence s_smi_armed;
        (i_group_smi && smi_q[5] && en3_q[3] && glb_q[1] && !i_reg_wr) [*3];
    endsequence

    chk_release_pin_idle: assert property ($rose(i_nrst) |-> !o_wake_event_oe)
        else $error("wake pin driven right after reset");
    chk_fan_wake_pin: assert property (s_fan_armed |-> ##[1:2] act)
        else $error("enabled fan event did not drive wake pin");
    chk_smi_wake_pin: assert property (s_smi_armed |-> ##[1:2] act)
        else $error("group interrupt did not drive wake pin");
    chk_global_off_block: assert property ((!glb_q[1] && !i_reg_wr) [*2] |-> !act)
        else $error("wake pin active with global enable off");
    chk_pushpull_drive: assert property ((!gp_q[7]) [*2] |-> o_wake_event_oe)
        else $error("push-pull pin not driven");
    chk_opendrain_low: assert property ((gp_q[7]) [*2] |-> !o_wake_event_out)
        else $error("open-drain pin drives high");
    chk_pin_ctrl_read: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h07
        |=> o_reg_rdata == $past(gp_q))
        else $error("pin control readback wrong");
    chk_enable_read: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h04
        |=> o_reg_rdata == $past(en1_q))
        else $error("enable readback wrong");
endmodule // wke_top_sva

bind wke_top wke_top_sva u_wke_top_sva (
    .i_clk            (i_clk),
    .i_nrst           (i_nrst),
    .i_reg_addr       (i_reg_addr),
    .i_reg_wdata      (i_reg_wdata),
    .i_reg_wr         (i_reg_wr),
    .i_reg_rd         (i_reg_rd),
    .o_reg_rdata      (o_reg_rdata),
    .i_fan_event      (i_fan_event),
    .i_group_smi      (i_group_smi),
    .o_wake_event_out (o_wake_event_out),
    .o_wake_event_oe  (o_wake_event_oe)
);

/* File: verif/wke_kbd_model.sv */
// Keyboard model sending serial frames on a pulled-up clock and data pair
`timescale 1ns/1ps
module wke_kbd_model #(
    parameter HALF_NS = 150,
    parameter IDLE_NS = 1000
) (
    output reg o_kclk,
    output reg o_kdata
);
    integer    n;
    reg [10:0] frm;
    initial
    begin
        o_kclk = 1'b1;
        o_kdata = 1'b1;
    end
    // Data dip with the clock left idle
    task dip;
    begin
        o_kdata = 1'b0;
        #(4 * HALF_NS);
        o_kdata = 1'b1;
    end
    endtask
    task send(input [7:0] code, input bad_par, input gap);
    begin
        frm = {1'b1, ~^code ^ bad_par, code, 1'b0};
        for (n = 0; n < 11; n = n + 1)
        begin
            o_kdata = frm[n];
            #(HALF_NS);
            if (gap && n == 5)
                #(4 * HALF_NS);
            o_kclk = 1'b0;
            #(HALF_NS);
            o_kclk = 1'b1;
        end
        o_kdata = 1'b1;
        #(IDLE_NS);
    end
    endtask
endmodule // wke_kbd_model

/* File: verif/testbench.sv */
// Self-checking bench for the wake-event block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    typedef struct {int k; logic en; logic glb; logic gs; logic act;} wke_row_t;
    logic       clk = 0, nrst = 0, snrst = 0, wr = 0, rd = 0;
    logic [7:0] addr = 0, wdata = 0, gpio = 0, v, gp = 8'h82;
    logic       ri1 = 1, ri2 = 1, mdat = 1, ext32 = 0, ir = 0, fan = 0, smi = 0;
    wire  [7:0] rdata;
    wire        pout, poe, kclk, kdat;
    int         err_total = 0, cmp_count = 0, i;
    wke_row_t   rows[7] = '{'{6, 1, 1, 1, 1}, '{4, 1, 0, 1, 0}, '{0, 1, 1, 1, 1}, '{1, 1, 1, 1, 1},
                            '{2, 1, 1, 1, 1}, '{3, 1, 1, 1, 1}, '{6, 0, 1, 0, 0}};
    always #4 clk = ~clk;
    always #40 ext32 = ~ext32;
    wke_top u_wke_top (
        .i_clk(clk), .i_nrst(nrst), .i_standby_nrst(snrst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_ring_indicator_1_n(ri1), .i_ring_indicator_2_n(ri2), .i_kbd_clk(kclk), .i_kbd_data(kdat),
        .i_mouse_data(mdat), .i_gpio(gpio), .i_ext_clock32(ext32), .i_ir_frame_valid(ir),
        .i_fan_event(fan), .i_group_smi(smi), .o_wake_event_out(pout), .o_wake_event_oe(poe));
    wke_kbd_model u_wke_kbd_model (.o_kclk(kclk), .o_kdata(kdat));
    function automatic logic act();
        return (poe ? pout : 1'b1) ^ gp[1];
    endfunction
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wreg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask
    task rreg(input [7:0] a);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    end
    endtask
    task fire(input int k);
    begin
        @(posedge clk);
        case (k)
            0: ri1 <= 1'b0;
            1: ri2 <= 1'b0;
            2: u_wke_kbd_model.dip();
            3: mdat <= 1'b0;
            4: ir <= 1'b1;
            default: fan <= 1'b1;
        endcase
        @(posedge clk);
        {ir, fan} <= 2'b00;
        idle(4);
        {ri1, ri2, mdat} <= 3'b111;
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        err_total++;
        $display("[FAIL] %0t run limit reached", $time);
        wrap_up;
    end
    initial
    begin
        idle(8);
        nrst <= 1'b1;
        snrst <= 1'b1;
        idle(2);
        `CHK(poe, 1'b0)
        rreg(8'h07);
        `CHK(v, 8'h82)
        rreg(8'hF0);
        `CHK(v, 8'h00)
        rreg(8'h40);
        `CHK(v, 8'h00)
        $display("reset test done");
        for (i = 0; i < 7; i++)
        begin
            wreg(8'h04, 8'(rows[i].en) << rows[i].k);
            wreg(8'h00, {6'h00, rows[i].glb, 1'b0});
            fire(rows[i].k);
            idle(8);
            rreg(8'h00);
            `CHK(v[0], rows[i].gs)
            `CHK(act(), rows[i].act)
            wreg(8'h00, {6'h00, rows[i].glb, 1'b1});
            rreg(8'h00);
            `CHK(v[0], rows[i].gs)
            wreg(8'h01, 8'hFF);
            wreg(8'h00, {6'h00, rows[i].glb, 1'b1});
            rreg(8'h00);
            `CHK(v[0], 1'b0)
            $display("row %0d done", i);
        end
        wreg(8'h09, 8'h01);
        wreg(8'h0A, 8'h02);
        @(posedge clk) gpio <= 8'h07;
        idle(6);
        rreg(8'h02);
        `CHK(v, 8'h06)
        wreg(8'h05, 8'h02);
        rreg(8'h02);
        `CHK(act(), 1'b1)
        wreg(8'h05, 8'h00);
        wreg(8'h02, 8'h00);
        rreg(8'h02);
        `CHK(v, 8'h06)
        wreg(8'h02, 8'hFF);
        @(posedge clk) gpio <= 8'h00;
        idle(6);
        rreg(8'h02);
        `CHK(v, 8'h03)
        wreg(8'h02, 8'hFF);
        $display("gpio test done");
        gp = 8'h00;
        wreg(8'h07, gp);
        wreg(8'h08, 8'h20);
        wreg(8'h06, 8'h08);
        wreg(8'h00, 8'h02);
        idle(3);
        `CHK({poe, pout}, 2'b10)
        @(posedge clk) smi <= 1'b1;
        idle(6);
        rreg(8'h03);
        `CHK(v, 8'h08)
        `CHK({poe, pout}, 2'b11)
        wreg(8'h06, 8'h00);
        idle(3);
        `CHK(act(), 1'b0)
        @(posedge clk) smi <= 1'b0;
        wreg(8'h03, 8'h08);
        rreg(8'h03);
        `CHK(v, 8'h00)
        gp = 8'h82;
        wreg(8'h07, gp);
        wreg(8'h00, 8'h03);
        $display("group interrupt test done");
        wreg(8'h5F, 8'h5A);
        wreg(8'h04, 8'h20);
        rreg(8'h04);
        `CHK(v, 8'h20)
        for (i = 0; i < 6; i++)
        begin
            wreg(8'hF0, {6'h00, i == 4, i != 5});
            wreg(8'h01, 8'hFF);
            wreg(8'h00, 8'h03);
            idle(i == 5 ? 20000 : 60);
            u_wke_kbd_model.send(i == 2 ? 8'h5B : 8'h5A, i == 1, i == 3);
            idle(20);
            rreg(8'h01);
            `CHK(v[5], i == 0 || i == 5)
            `CHK(act(), i == 0 || i == 5)
            $display("frame %0d done", i);
        end
        gpio <= 8'h01;
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        idle(2);
        rreg(8'h5F);
        `CHK(v, 8'h5A)
        rreg(8'h02);
        `CHK(v, 8'h00)
        snrst <= 1'b0;
        idle(2);
        snrst <= 1'b1;
        idle(2);
        rreg(8'h5F);
        `CHK(v, 8'h00)
        $display("standby reset test done");
        wrap_up;
    end
endmodule // testbench
